// File: rtl/csc_flag.sv
/*
 * csc_flag: one sticky event flag, set by hardware, cleared by a request.
 * assumes: set and clear are one-cycle conditions on clk_in.
 */
`timescale 1ns/10ps
module csc_flag (
    // clock and power-up reset
    input  wire logic clk_in,
    input  wire logic reset_in,
    // set and clear requests
    input  wire logic set_in,
    input  wire logic clear_in,
    // flag state
    output logic      flag_out
);

    logic flag_d;

    // a set in the same cycle as a clear keeps the flag high
    always_comb begin
        flag_d = flag_out;
        if (clear_in) begin
            flag_d = 1'b0;
        end
        if (set_in) begin
            flag_d = 1'b1;
        end
    end

    // flag register, reset by power-up reset only
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            flag_out <= 1'b0;
        end else begin
            flag_out <= flag_d;
        end
    end

endmodule : csc_flag

// File: rtl/csc_link_state.sv
/*
 * csc_link_state: tracks the physical layer link, speed and duplex levels.
 * assumes: phy status levels are synchronous to clk_in.
 */
`timescale 1ns/10ps
module csc_link_state
    import csc_pkg::*;
(
    // clock and power-up reset
    input  wire logic            clk_in,
    input  wire logic            reset_in,
    // live physical layer status
    input  wire logic            link_valid_in,
    input  wire logic            speed_100_in,
    input  wire logic            full_duplex_in,
    // register image
    output logic [csc_pkg::LS_W-1:0] state_out
);

    logic [LS_W-1:0] state_d;

    // follow the phy every cycle; upper bits stay zero
    always_comb begin
        state_d                = LS_RESET;
        state_d[LS_LINK_BIT]   = link_valid_in;
        state_d[LS_SPEED_BIT]  = speed_100_in;
        state_d[LS_DUPLEX_BIT] = full_duplex_in;
    end

    // image register, link bit reads zero after reset
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            state_out <= LS_RESET;
        end else begin
            state_out <= state_d;
        end
    end

endmodule : csc_link_state

// File: rtl/csc_pkg.sv
/*
 * csc_pkg: shared constants of the card status change register bank.
 * assumes: byte addresses on the control/status access port, 32-bit data.
 */
package csc_pkg;

    // register port widths
    localparam int unsigned ADDR_W         = 8;
    localparam int unsigned DATA_W         = 32;
    localparam int unsigned BE_W           = DATA_W / 8;

    // byte offsets inside the control/status space
    localparam logic [ADDR_W-1:0] OFF_LINK_STATE  = 8'h2c; // byte register, lane 0
    localparam logic [ADDR_W-1:0] OFF_EVENT_FLAGS = 8'h30; // base of the event group
    localparam logic [ADDR_W-1:0] OFF_EVENT_MASKS = 8'h34;

    // link state byte fields
    localparam int unsigned LS_LINK_BIT    = 0;
    localparam int unsigned LS_SPEED_BIT   = 1;
    localparam int unsigned LS_DUPLEX_BIT  = 2;
    localparam int unsigned LS_W           = 8;
    localparam logic [LS_W-1:0] LS_RESET   = 8'h00;

    // event and mask fields
    localparam int unsigned EV_IRQ_BIT     = 15;
    localparam int unsigned EV_WAKE_BIT    = 4;
    localparam int unsigned EV_BATT_RDY    = 2;
    localparam int unsigned EV_BATT_WP     = 1;
    localparam int unsigned MK_IRQ_BIT     = 15;
    localparam int unsigned MK_WAKE_BIT    = 14;
    localparam int unsigned MK_AUDIO_HI    = 6;
    localparam int unsigned MK_AUDIO_LO    = 5;
    localparam int unsigned MK_GENERAL_WAKE_BIT_BIT   = 4;
    localparam int unsigned MK_BATT_RDY    = 2;
    localparam int unsigned MK_BATT_WP     = 1;

    // writable bits of the mask register and reset images
    localparam logic [DATA_W-1:0] MK_WRITABLE  = 32'h0000_c076;
    localparam logic [DATA_W-1:0] EV_RESET     = 32'h0000_0000;
    localparam logic [DATA_W-1:0] MK_RESET     = 32'h0000_0000;
    localparam logic [DATA_W-1:0] RD_UNMAPPED  = 32'h0000_0000;

    // register selected by an access
    typedef enum logic [1:0] {
        CSC_SEL_NONE  = 2'h0,
        CSC_SEL_LINK  = 2'h1,
        CSC_SEL_EVENT = 2'h2,
        CSC_SEL_MASK  = 2'h3
    } csc_sel_t;

endpackage : csc_pkg

// File: rtl/csc_status_change_regs.sv
/*
 * csc_status_change_regs: link state byte, function event flags and event
 * masks of a network function in card bus mode, with the status change and
 * interrupt outputs they drive.
 * assumes: one clock; reset_in is the power-up reset; the host bridge
 * reaches the registers over the control/status access port below.
 * phy levels and event sources are synchronous to clk_in;
 * power management write-one clears arrive as pulses;
 * software keeps off the bank in pci mode, where accesses
 * are dropped without an answer.
 */
//
// What this block does
// - read-only link byte, card bus only, upper five bits read zero.
// - link byte bit 2 shows duplex, one full, zero half.
// - link byte bit 1 shows speed, one 100 Mbps, zero 10 Mbps.
// - link byte bit 0 shows link valid, zero after reset.
// - only interrupt and general wake event bits do anything.
// - every status change register resets only on power-up reset.
// - event bit 15 sets when the interrupt source is active, mask ignored.
// - event bit 15 clears on write one only once source is serviced.
// - event bit 4 sets when the wake source rises, mask ignored.
// - write one to bit 4 clears it and the power status flag.
// - write one to the power status flag also clears event bit 4.
// - event bits 2 and 1 are battery positions, zero after reset.
// - mask bit 15 low blocks the interrupt line, events unaffected.
// - interrupt line needs mask bit 15 and the control block enable.
// - mask bit 14 low blocks the status change line unless power enable is set, events unaffected.
// - mask bit 14 works together with mask bit 4.
// - mask bits 6:5 hold the audio enable setting, reset zero.
// - status change from the wake event with wake and general masks, or with power enable.
// - in card bus mode, clearing wake status in the power driver register clears bit 4.
`timescale 1ns/10ps
module csc_status_change_regs
    import csc_pkg::*;
(
    // clock and power-up reset
    input  wire logic                    clk_in,
    input  wire logic                    reset_in,
    // operating mode
    input  wire logic                    cardbus_mode_in,
    // control/status access port
    input  wire logic [csc_pkg::ADDR_W-1:0] csr_addr_in,
    input  wire logic                    csr_write_in,
    input  wire logic                    csr_read_in,
    input  wire logic [csc_pkg::BE_W-1:0]   csr_byte_en_in,
    input  wire logic [csc_pkg::DATA_W-1:0] csr_wdata_in,
    output logic [csc_pkg::DATA_W-1:0]   csr_rdata_out,
    output logic                         csr_rvalid_out,
    // physical layer status
    input  wire logic                    link_valid_in,
    input  wire logic                    speed_100_in,
    input  wire logic                    full_duplex_in,
    // function event sources
    input  wire logic                    irq_source_in,
    input  wire logic                    wake_source_in,
    // power management and system control block
    input  wire logic                    pm_enable_in,
    input  wire logic                    pm_status_write_one_in,
    input  wire logic                    driver_wake_clear_in,
    input  wire logic                    irq_control_enable_in,
    // outputs to the bus and power logic
    output logic                         irq_assert_out,
    output logic                         status_change_out,
    output logic                         pm_status_clear_out,
    output logic [1:0]                   pulse_audio_enable_out
);

    // decode of an access address, used by both read and write paths
    // unmapped offsets select nothing and read zero
    function automatic csc_sel_t csc_decode(input logic [ADDR_W-1:0] addr);
        csc_sel_t sel;
        sel = CSC_SEL_NONE;
        case (addr)
            OFF_LINK_STATE:  sel = CSC_SEL_LINK;
            OFF_EVENT_FLAGS: sel = CSC_SEL_EVENT;
            OFF_EVENT_MASKS: sel = CSC_SEL_MASK;
            default:         sel = CSC_SEL_NONE;
        endcase
        return sel;
    endfunction : csc_decode

    // expand byte enables to a bit mask
    // a lane with its enable low keeps its bits
    function automatic logic [DATA_W-1:0] csc_lanes(input logic [BE_W-1:0] be);
        logic [DATA_W-1:0] m;
        m = '0;
        for (int i = 0; i < BE_W; i++) begin
            m[i*8 +: 8] = {8{be[i]}};
        end
        return m;
    endfunction : csc_lanes

    // access qualification
    csc_sel_t          wr_sel;
    csc_sel_t          rd_sel;
    logic              wr_ok;
    logic              rd_ok;
    logic [DATA_W-1:0] wr_bits;

    // register state
    // event image is rebuilt from the two flags
    logic [LS_W-1:0]   link_state_byte;
    logic [DATA_W-1:0] function_event_masks_q;
    logic [DATA_W-1:0] function_event_masks_d;
    logic [DATA_W-1:0] function_event_flags;
    logic              irq_event_bit;
    logic              general_wake_bit;
    logic              wake_source_q;
    logic              wake_source_d;
    logic              wake_rise;

    // clear requests for the two live event bits
    // each clear is a one-cycle condition
    logic              irq_clear;
    logic              wake_clear;
    logic              wake_write_one;

    // read path and outputs
    logic [DATA_W-1:0] csr_rdata_d;
    logic              csr_rvalid_d;
    logic              irq_assert_d;
    logic              status_change_d;
    logic              pm_status_clear_d;

    // address decode for the write and read paths
    always_comb begin
        wr_sel  = csc_decode(csr_addr_in);
        rd_sel  = csc_decode(csr_addr_in);
    end

    // accesses count only in card bus mode; pci mode leaves everything alone
    always_comb begin
        wr_ok   = csr_write_in && cardbus_mode_in;
        rd_ok   = csr_read_in && cardbus_mode_in;
        wr_bits = csr_wdata_in & csc_lanes(csr_byte_en_in);
    end

    // link state byte follows the phy; it has no write path
    // a write to its offset finds nothing to change
    csc_link_state u_link_state (
        .clk_in         (clk_in),
        .reset_in       (reset_in),
        .link_valid_in  (link_valid_in),
        .speed_100_in   (speed_100_in),
        .full_duplex_in (full_duplex_in),
        .state_out      (link_state_byte)
    );

    // wake source history, so a held source does not defeat a clear
    always_comb begin
        wake_source_d = wake_source_in;
    end

    // zero after reset matches the idle source level
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            wake_source_q <= 1'b0;
        end else begin
            wake_source_q <= wake_source_d;
        end
    end

    // a new wake is a low to high step of the source
    always_comb begin
        wake_rise      = wake_source_in && !wake_source_q;
    end

    // interrupt clear only once the source is serviced
    always_comb begin
        irq_clear      = wr_ok && (wr_sel == CSC_SEL_EVENT)
                         && wr_bits[EV_IRQ_BIT] && !irq_source_in;
    end

    // three ways to clear the wake bit
    always_comb begin
        wake_write_one = wr_ok && (wr_sel == CSC_SEL_EVENT)
                         && wr_bits[EV_WAKE_BIT];
        wake_clear     = wake_write_one
                         || pm_status_write_one_in
                         || (driver_wake_clear_in && cardbus_mode_in);
    end

    // interrupt event flag, set by the live source whatever the mask says
    // a clear while the source is high loses to the set
    csc_flag u_irq_flag (
        .clk_in   (clk_in),
        .reset_in (reset_in),
        .set_in   (irq_source_in),
        .clear_in (irq_clear),
        .flag_out (irq_event_bit)
    );

    // general wake event flag, set on each new wake, mask ignored
    // a held source sets the bit only once
    csc_flag u_wake_flag (
        .clk_in   (clk_in),
        .reset_in (reset_in),
        .set_in   (wake_rise),
        .clear_in (wake_clear),
        .flag_out (general_wake_bit)
    );

    // event register image; battery and reserved positions read zero
    // the battery positions have no source here
    always_comb begin
        function_event_flags              = EV_RESET;
        function_event_flags[EV_IRQ_BIT]  = irq_event_bit;
        function_event_flags[EV_WAKE_BIT] = general_wake_bit;
    end

    // mask register: only the defined bits take writes
    // the audio field is plain storage
    always_comb begin
        function_event_masks_d = function_event_masks_q;
        if (wr_ok && (wr_sel == CSC_SEL_MASK)) begin
            function_event_masks_d = (function_event_masks_q & ~(MK_WRITABLE
                                     & csc_lanes(csr_byte_en_in)))
                                     | (wr_bits & MK_WRITABLE);
        end
    end

    // mask register storage, power-up reset only
    // no soft reset reaches here, masks survive it
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            function_event_masks_q <= MK_RESET;
        end else begin
            function_event_masks_q <= function_event_masks_d;
        end
    end

    // interrupt line gating; masks never touch the events
    // the control block enable is a live level
    always_comb begin
        irq_assert_d      = irq_event_bit
                            && function_event_masks_q[MK_IRQ_BIT]
                            && irq_control_enable_in;
    end

    // status change gating; the power path still needs a wake
    always_comb begin
        status_change_d   = general_wake_bit
                            && ((function_event_masks_q[MK_WAKE_BIT]
                                 && function_event_masks_q[MK_GENERAL_WAKE_BIT_BIT])
                                || pm_enable_in);
    end

    // a one written to the wake bit clears the power flag
    always_comb begin
        pm_status_clear_d = wake_write_one;
    end

    // read mux, answered one cycle after the request
    // pci mode reads get no answer at all
    // the link byte sits in lane 0, upper lanes zero
    always_comb begin
        csr_rdata_d  = RD_UNMAPPED;
        csr_rvalid_d = rd_ok;
        if (rd_ok) begin
            case (rd_sel)
                CSC_SEL_LINK:  csr_rdata_d = {{(DATA_W-LS_W){1'b0}}, link_state_byte};
                CSC_SEL_EVENT: csr_rdata_d = function_event_flags;
                CSC_SEL_MASK:  csr_rdata_d = function_event_masks_q;
                default:       csr_rdata_d = RD_UNMAPPED;
            endcase
        end
    end

    // read answer registers; data returns to zero after the answer
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            csr_rdata_out  <= RD_UNMAPPED;
            csr_rvalid_out <= 1'b0;
        end else begin
            csr_rdata_out  <= csr_rdata_d;
            csr_rvalid_out <= csr_rvalid_d;
        end
    end

    // line and pulse registers, so pins never glitch
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            irq_assert_out      <= 1'b0;
            status_change_out   <= 1'b0;
            pm_status_clear_out <= 1'b0;
        end else begin
            irq_assert_out      <= irq_assert_d;
            status_change_out   <= status_change_d;
            pm_status_clear_out <= pm_status_clear_d;
        end
    end

    // audio copy, taken from the next mask so it moves with it
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            pulse_audio_enable_out <= 2'h0;
        end else begin
            pulse_audio_enable_out <= function_event_masks_d[MK_AUDIO_HI:MK_AUDIO_LO];
        end
    end

endmodule : csc_status_change_regs

// File: test/csc_host_model.sv
/* Host bridge model: drives the control/status access port.
   Assumes: reads answer one cycle after the strobe edge. */
`timescale 1ns/10ps
module csc_host_model
    import csc_pkg::*;
(
    // clock
    input  wire logic                       clk_in,
    // access port towards the bank
    output logic                            cardbus_mode_out,
    output logic [csc_pkg::ADDR_W-1:0]      addr_out,
    output logic                            write_out,
    output logic                            read_out,
    output logic [csc_pkg::BE_W-1:0]        byte_en_out,
    output logic [csc_pkg::DATA_W-1:0]      wdata_out,
    input  wire logic [csc_pkg::DATA_W-1:0] rdata_in,
    input  wire logic                       rvalid_in
);
    // idle bus in card bus mode
    initial begin
        cardbus_mode_out = 1'b1;
        write_out = 1'b0;
        read_out = 1'b0;
        addr_out = 8'h00;
        byte_en_out = 4'h0;
        wdata_out = 32'h0;
    end
    // one write strobe; afterwards address and data lines show the inverse of the last value
    task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
        @(negedge clk_in);
        addr_out = a;
        byte_en_out = be;
        wdata_out = d;
        write_out = 1'b1;
        @(negedge clk_in);
        write_out = 1'b0;
        addr_out = ~a;
        wdata_out = ~d;
    endtask : wr
    // one read strobe; ok tells whether an answer came
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic ok);
        @(negedge clk_in);
        addr_out = a;
        read_out = 1'b1;
        @(negedge clk_in);
        ok = rvalid_in;
        d = rdata_in;
        read_out = 1'b0;
        addr_out = ~a;
    endtask : rd
    // software stays off the bank in pci mode unless told otherwise
    task automatic mode(input logic cb);
        @(negedge clk_in);
        cardbus_mode_out = cb;
    endtask : mode
endmodule : csc_host_model

// File: test/csc_status_change_regs_asserts.sv
/* Port checker of the status change register bank.
   Assumes: bound into csc_status_change_regs, one clock, sync reset. */
`timescale 1ns/10ps
module csc_status_change_regs_asserts
    import csc_pkg::*;
(
    // clock and reset
    input wire logic                         clk_in,
    input wire logic                         reset_in,
    // access port
    input wire logic                         cardbus_mode_in,
    input wire logic [csc_pkg::ADDR_W-1:0]   csr_addr_in,
    input wire logic                         csr_write_in,
    input wire logic                         csr_read_in,
    input wire logic [csc_pkg::BE_W-1:0]     csr_byte_en_in,
    input wire logic [csc_pkg::DATA_W-1:0]   csr_wdata_in,
    input wire logic [csc_pkg::DATA_W-1:0]   csr_rdata_out,
    input wire logic                         csr_rvalid_out,
    // sources and outputs
    input wire logic                         wake_source_in,
    input wire logic                         pm_enable_in,
    input wire logic                         pm_status_write_one_in,
    input wire logic                         driver_wake_clear_in,
    input wire logic                         irq_control_enable_in,
    input wire logic                         irq_assert_out,
    input wire logic                         status_change_out,
    input wire logic                         pm_status_clear_out,
    input wire logic [1:0]                   pulse_audio_enable_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (reset_in);
    // qualified lane 0 writes and wake clears
    wire logic acc = cardbus_mode_in & csr_write_in & csr_byte_en_in[0];
    wire logic wr_wake = acc & (csr_addr_in == OFF_EVENT_FLAGS) & csr_wdata_in[EV_WAKE_BIT];
    wire logic wr_mask = acc & (csr_addr_in == OFF_EVENT_MASKS);
    wire logic clr = wr_wake | pm_status_write_one_in | driver_wake_clear_in;
    read_answer_a: assert property (csr_read_in & cardbus_mode_in |=> csr_rvalid_out)
        else $error("read not answered");
    pci_drop_a: assert property (!cardbus_mode_in & csr_read_in |=> !csr_rvalid_out)
        else $error("read answered in pci mode");
    idle_zero_a: assert property (!csr_rvalid_out |-> csr_rdata_out == 32'h0)
        else $error("read data not zero when idle");
    link_upper_a: assert property (csr_rvalid_out && $past(csr_addr_in) == OFF_LINK_STATE
        |-> csr_rdata_out[31:3] == 29'h0) else $error("link byte upper bits set");
    irq_gate_a: assert property (irq_assert_out |-> $past(irq_control_enable_in))
        else $error("interrupt without control enable");
    wake_change_a: assert property ($rose(wake_source_in) & pm_enable_in & !clr
        ##1 pm_enable_in & !clr |=> status_change_out) else $error("no status change");
    pm_clear_a: assert property (pm_status_clear_out == $past(wr_wake))
        else $error("power status clear pulse wrong");
    audio_follow_a: assert property (wr_mask |=>
        pulse_audio_enable_out == $past(csr_wdata_in[6:5])) else $error("audio bits wrong");
    irq_cov: cover property (irq_assert_out);
    change_cov: cover property (status_change_out);
    clear_cov: cover property (pm_status_clear_out);
endmodule : csc_status_change_regs_asserts

bind csc_status_change_regs csc_status_change_regs_asserts csc_status_change_regs_asserts_i (
    .clk_in(clk_in), .reset_in(reset_in), .cardbus_mode_in(cardbus_mode_in),
    .csr_addr_in(csr_addr_in), .csr_write_in(csr_write_in), .csr_read_in(csr_read_in),
    .csr_byte_en_in(csr_byte_en_in), .csr_wdata_in(csr_wdata_in),
    .csr_rdata_out(csr_rdata_out), .csr_rvalid_out(csr_rvalid_out),
    .wake_source_in(wake_source_in), .pm_enable_in(pm_enable_in),
    .pm_status_write_one_in(pm_status_write_one_in), .driver_wake_clear_in(driver_wake_clear_in),
    .irq_control_enable_in(irq_control_enable_in), .irq_assert_out(irq_assert_out),
    .status_change_out(status_change_out), .pm_status_clear_out(pm_status_clear_out),
    .pulse_audio_enable_out(pulse_audio_enable_out));

// File: test/test_csc_status_change_regs.sv
/* Self-checking bench of the status change register bank.
   Assumes: host model drives the access port, bench drives sources. */
`timescale 1ns/10ps
module test_csc_status_change_regs;
    import csc_pkg::*;
    logic clk_in, reset_in, cb, wr, rd, rvalid, lnk, spd, dup, irq_src, wake_src;
    logic pm_en, pm_w1, drv_clr, irq_en, irq_out, sc_out, pm_clr;
    logic [7:0] addr;
    logic [3:0] be;
    logic [31:0] wdata, rdata, d;
    logic [1:0] audio;
    logic ok;
    int errors, n_checks;
    csc_host_model csc_host_model_i (.clk_in(clk_in), .cardbus_mode_out(cb), .addr_out(addr),
        .write_out(wr), .read_out(rd), .byte_en_out(be), .wdata_out(wdata), .rdata_in(rdata),
        .rvalid_in(rvalid));
    csc_status_change_regs csc_status_change_regs_i (.clk_in(clk_in), .reset_in(reset_in),
        .cardbus_mode_in(cb), .csr_addr_in(addr), .csr_write_in(wr), .csr_read_in(rd),
        .csr_byte_en_in(be), .csr_wdata_in(wdata), .csr_rdata_out(rdata), .csr_rvalid_out(rvalid),
        .link_valid_in(lnk), .speed_100_in(spd), .full_duplex_in(dup), .irq_source_in(irq_src),
        .wake_source_in(wake_src), .pm_enable_in(pm_en), .pm_status_write_one_in(pm_w1),
        .driver_wake_clear_in(drv_clr), .irq_control_enable_in(irq_en), .irq_assert_out(irq_out),
        .status_change_out(sc_out), .pm_status_clear_out(pm_clr), .pulse_audio_enable_out(audio));
    // compare one value
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    // read a register and compare answer and data
    task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] exp);
        csc_host_model_i.rd(a, d, ok);
        chk(what, {31'h0, 1'b1}, {31'h0, ok});
        chk(what, exp, d);
    endtask : rchk
    task automatic tick(input int n);
        repeat (n) @(negedge clk_in);
    endtask : tick
    task automatic wake_pulse;
        wake_src = 1'b1;
        tick(1);
        wake_src = 1'b0;
        tick(2);
    endtask : wake_pulse
    task automatic end_sim;
        $display("checks %0d mismatches %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : end_sim
    // clock
    initial begin
        clk_in = 1'b0;
        forever #5 clk_in = ~clk_in;
    end
    // watchdog
    initial begin
        #200000;
        errors++;
        $display("watchdog expired");
        end_sim();
    end
    // main sequence
    initial begin
        {reset_in, lnk, spd, dup, irq_src, wake_src, pm_en, pm_w1, drv_clr, irq_en} = 10'h200;
        errors = 0;
        n_checks = 0;
        tick(6);
        reset_in = 1'b0;
        rchk("event", OFF_EVENT_FLAGS, EV_RESET);
        rchk("mask", OFF_EVENT_MASKS, MK_RESET);
        rchk("link", OFF_LINK_STATE, 32'h0);
        for (int i = 0; i < 8; i++) begin
            {dup, spd, lnk} = i[2:0];
            tick(2);
            rchk("link", OFF_LINK_STATE, {29'h0, i[2:0]});
        end
        csc_host_model_i.wr(OFF_LINK_STATE, 4'hf, 32'hffff_fff8);
        rchk("link ro", OFF_LINK_STATE, 32'h7);
        rchk("unmapped", 8'h38, RD_UNMAPPED);
        csc_host_model_i.wr(OFF_EVENT_MASKS, 4'hf, 32'hffff_ffff);
        chk("audio", 32'h3, {30'h0, audio});
        rchk("mask all", OFF_EVENT_MASKS, MK_WRITABLE);
        csc_host_model_i.wr(OFF_EVENT_MASKS, 4'h1, 32'h0);
        rchk("mask lane", OFF_EVENT_MASKS, 32'hc000);
        csc_host_model_i.wr(OFF_EVENT_FLAGS, 4'hf, 32'hffff_ffff);
        rchk("event ro", OFF_EVENT_FLAGS, 32'h0);
        $display("registers done");
        csc_host_model_i.wr(OFF_EVENT_MASKS, 4'hf, 32'h0);
        irq_en = 1'b1;
        irq_src = 1'b1;
        tick(3);
        chk("irq masked", 32'h0, {31'h0, irq_out});
        rchk("irq event", OFF_EVENT_FLAGS, 32'h8000);
        csc_host_model_i.wr(OFF_EVENT_MASKS, 4'hf, 32'h8000);
        tick(2);
        chk("irq on", 32'h1, {31'h0, irq_out});
        irq_en = 1'b0;
        tick(2);
        chk("irq off", 32'h0, {31'h0, irq_out});
        csc_host_model_i.wr(OFF_EVENT_FLAGS, 4'hf, 32'h8000);
        rchk("irq busy", OFF_EVENT_FLAGS, 32'h8000);
        irq_src = 1'b0;
        csc_host_model_i.wr(OFF_EVENT_FLAGS, 4'hf, 32'h0);
        rchk("irq w0", OFF_EVENT_FLAGS, 32'h8000);
        csc_host_model_i.wr(OFF_EVENT_FLAGS, 4'hf, 32'h8000);
        rchk("irq clr", OFF_EVENT_FLAGS, 32'h0);
        $display("interrupt done");
        csc_host_model_i.wr(OFF_EVENT_MASKS, 4'hf, 32'h0);
        wake_pulse();
        rchk("wake", OFF_EVENT_FLAGS, 32'h10);
        chk("sc masked", 32'h0, {31'h0, sc_out});
        csc_host_model_i.wr(OFF_EVENT_MASKS, 4'hf, 32'h4000);
        tick(2);
        chk("sc wake_mask_bit", 32'h0, {31'h0, sc_out});
        csc_host_model_i.wr(OFF_EVENT_MASKS, 4'hf, 32'h4010);
        tick(2);
        chk("sc both", 32'h1, {31'h0, sc_out});
        csc_host_model_i.wr(OFF_EVENT_MASKS, 4'hf, 32'h0);
        pm_en = 1'b1;
        tick(2);
        chk("sc pm", 32'h1, {31'h0, sc_out});
        csc_host_model_i.wr(OFF_EVENT_FLAGS, 4'h1, 32'h10);
        chk("pm clear", 32'h1, {31'h0, pm_clr});
        rchk("wake w1", OFF_EVENT_FLAGS, 32'h0);
        chk("sc off", 32'h0, {31'h0, sc_out});
        wake_pulse();
        pm_w1 = 1'b1;
        tick(1);
        pm_w1 = 1'b0;
        rchk("wake pm", OFF_EVENT_FLAGS, 32'h0);
        wake_pulse();
        drv_clr = 1'b1;
        tick(1);
        drv_clr = 1'b0;
        rchk("wake drv", OFF_EVENT_FLAGS, 32'h0);
        $display("wake done");
        csc_host_model_i.mode(1'b0);
        csc_host_model_i.wr(OFF_EVENT_MASKS, 4'hf, 32'h8000);
        csc_host_model_i.rd(OFF_EVENT_MASKS, d, ok);
        chk("pci read", 32'h0, {31'h0, ok});
        csc_host_model_i.mode(1'b1);
        rchk("pci write", OFF_EVENT_MASKS, 32'h0);
        csc_host_model_i.wr(OFF_EVENT_MASKS, 4'hf, 32'hc076);
        reset_in = 1'b1;
        tick(2);
        reset_in = 1'b0;
        rchk("mask rst", OFF_EVENT_MASKS, MK_RESET);
        $display("mode and reset done");
        end_sim();
    end
endmodule : test_csc_status_change_regs
